// >>> design/ssr_top.sv
// Synchronous serial receive path with Wishbone register port
//
// Our own choices: the register offsets and the Wishbone slave port.
`include "ssr_params.svh"
`default_nettype none
module ssr_top #(
	parameter int DEPTH = `SSR_FIFO_DEPTH,
	parameter int BAUD_W = 16
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Shared clock/transmit pin
	input  wire logic        shared_clock_transmit_pin_i,
	output logic             shared_clock_transmit_pin_o,
	output logic             shared_clock_transmit_pin_oe_n_o,
	// Receive data pin
	input  wire logic        rx_data_pin_i,
	// Receive interrupt
	output logic             rx_irq_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	ssr_pkg::ssr_ctrl_t      ctrl;
	ssr_pkg::ssr_status_t    status;
	ssr_pkg::ssr_rx_state_t  state;
	logic [BAUD_W-1:0]       baud;
	logic [BAUD_W-1:0]       baud_div;
	logic                    port_rst;
	logic                    wb_req;
	logic                    wr_ctrl;
	logic                    wr_baud;
	logic                    rd_data;
	logic                    ck_meta;
	logic                    ck_sync;
	logic                    ck_prev;
	logic                    dt_meta;
	logic                    dt_sync;
	logic                    baud_tick;
	logic                    rx_enable;
	logic                    master_run;
	logic                    sample;
	logic [8:0]              shreg;
	logic [3:0]              bit_cnt;
	logic [3:0]              char_bits;
	logic                    char_done;
	logic [8:0]              char_val;
	logic [8:0]              fifo_mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] head;
	logic [$clog2(DEPTH):0]  count;
	logic                    push;
	logic                    pop;
	logic                    overrun;
	logic                    ovr_single;
	logic                    ovr_set;
	logic                    ovr_clear;
	logic [31:0]             next_rdata;

	function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
		hit = (adr[3:2] == ofs[3:2]);
	endfunction

	function automatic logic [$clog2(DEPTH)-1:0] wrap(input logic [$clog2(DEPTH):0] p);
		wrap = p[$clog2(DEPTH)-1:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Wishbone decode

	// Ack high keeps one request from being taken twice
	assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctrl = wb_req && wb_we_i && hit(wb_adr_i, `SSR_OFS_CTRL) && wb_sel_i[0];
	assign wr_baud = wb_req && wb_we_i && hit(wb_adr_i, `SSR_OFS_BAUD);
	assign rd_data = wb_req && !wb_we_i && hit(wb_adr_i, `SSR_OFS_DATA);

	// Clearing port enable resets the receive path except the pin synchronisers
	assign port_rst = rst_i || !ctrl.serial_port_enable;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit(wb_adr_i, `SSR_OFS_CTRL))
			next_rdata[7:0] = ctrl;
		else if (hit(wb_adr_i, `SSR_OFS_STATUS))
			next_rdata[4:0] = status;
		else if (hit(wb_adr_i, `SSR_OFS_DATA))
			next_rdata[7:0] = (count != '0) ? fifo_mem[head][7:0] : 8'h00;
		else if (hit(wb_adr_i, `SSR_OFS_BAUD))
			next_rdata[BAUD_W-1:0] = baud;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_req && !wb_we_i)
			wb_dat_o <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Control and baud registers

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `SSR_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= wb_dat_i[7:0];
		end else if (char_done && !ctrl.continuous_receive_enable) begin
			// Single receive ends after one character
			ctrl.single_receive_enable <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud <= `SSR_BAUD_RESET;
		end else if (wr_baud) begin
			if (wb_sel_i[0])
				baud[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				baud[15:8] <= wb_dat_i[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Link clock synchroniser and edge history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ck_meta <= 1'b0;
			ck_sync <= 1'b0;
			ck_prev <= 1'b0;
		end else begin
			ck_meta <= shared_clock_transmit_pin_i;
			ck_sync <= ck_meta;
			ck_prev <= ck_sync;
		end
	end

	// Receive data synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dt_meta <= 1'b0;
			dt_sync <= 1'b0;
		end else begin
			dt_meta <= rx_data_pin_i;
			dt_sync <= dt_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master bit clock

	// R16 start on enable
	assign rx_enable  = ctrl.single_receive_enable || ctrl.continuous_receive_enable;
	// Clock stops while an overrun stalls reception
	assign master_run = ctrl.master_clock_source_select && rx_enable
		&& state != ssr_pkg::SSR_RX_STALL;
	// Narrow divisor uses the low byte only
	assign baud_div   = ctrl.wide_baud_generator_select ? baud
		: {{(BAUD_W-8){1'b0}}, baud[7:0]};

	ssr_baud_gen #(
		.W (BAUD_W)
	) u_baud (
		.clk_i  (clk_i),
		.rst_i  (port_rst),
		.en_i   (master_run),
		.div_i  (baud_div),
		.tick_o (baud_tick)
	);

	// R20 master drives clock
	always_ff @(posedge clk_i) begin
		if (port_rst)
			shared_clock_transmit_pin_o <= 1'b0;
		else if (!master_run)
			shared_clock_transmit_pin_o <= 1'b0;
		else if (baud_tick)
			shared_clock_transmit_pin_o <= !shared_clock_transmit_pin_o;
	end

	// R2 slave releases pin
	always_ff @(posedge clk_i) begin
		if (port_rst)
			shared_clock_transmit_pin_oe_n_o <= 1'b1;
		else
			shared_clock_transmit_pin_oe_n_o <= !ctrl.master_clock_source_select;
	end

	////////////////////////////////////////////////////////////////////////
	// Bit sampling

	// R3 trailing edge sample
	// R1 slave uses pin clock
	always_comb begin
		if (ctrl.master_clock_source_select)
			sample = master_run && baud_tick && shared_clock_transmit_pin_o;
		else
			sample = ck_prev && !ck_sync;
		sample = sample && rx_enable && state != ssr_pkg::SSR_RX_STALL;
	end

	// R12 nine or eight bits
	assign char_bits = ctrl.nine_bit_receive_enable ? `SSR_BITS_LONG : `SSR_BITS_SHORT;
	assign char_done = sample && (bit_cnt == char_bits - 4'h1);
	assign char_val  = ctrl.nine_bit_receive_enable
		? {dt_sync, shreg[8:1]} : {1'b0, dt_sync, shreg[8:2]};

	// Bits enter at the top, first bit ends lowest
	// R4 one bit per clock
	always_ff @(posedge clk_i) begin
		if (port_rst) begin
			shreg   <= 9'h000;
			bit_cnt <= 4'h0;
		end else if (!rx_enable) begin
			bit_cnt <= 4'h0;
		end else if (sample) begin
			shreg   <= {dt_sync, shreg[8:1]};
			bit_cnt <= char_done ? 4'h0 : bit_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (port_rst)
			state <= ssr_pkg::SSR_RX_IDLE;
		else begin
			case (state)
				ssr_pkg::SSR_RX_IDLE: begin
					if (sample)
						state <= ssr_pkg::SSR_RX_SHIFT;
				end
				ssr_pkg::SSR_RX_SHIFT: begin
					if (ovr_set)
						state <= ssr_pkg::SSR_RX_STALL;
					else if (char_done || !rx_enable)
						state <= ssr_pkg::SSR_RX_IDLE;
				end
				ssr_pkg::SSR_RX_STALL: begin
					if (ovr_clear)
						state <= ssr_pkg::SSR_RX_IDLE;
				end
				default: state <= ssr_pkg::SSR_RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive FIFO

	// A pop in the same cycle frees the slot for the new character
	// R6 two-character store
	assign push = char_done && !overrun && (count != DEPTH[$clog2(DEPTH):0] || pop);
	assign pop  = rd_data && count != '0;

	// New character goes behind the stored ones
	always_ff @(posedge clk_i) begin
		if (push)
			fifo_mem[wrap(count + {1'b0, head})] <= char_val;
	end

	always_ff @(posedge clk_i) begin
		if (port_rst)
			head <= '0;
		else if (pop)
			head <= head + 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (port_rst)
			count <= '0;
		else
			count <= count + push - pop;
	end

	////////////////////////////////////////////////////////////////////////
	// Overrun

	// R7 third char sets overrun
	assign ovr_set = char_done && count == DEPTH[$clog2(DEPTH):0] && !pop && !overrun;

	// R10 read clears single
	// R11 continuous off clears
	assign ovr_clear = overrun && (ovr_single ? rd_data : !ctrl.continuous_receive_enable);

	// Set wins over clear in the same cycle
	// R9 no software write
	// R8 keep stored data
	always_ff @(posedge clk_i) begin
		if (port_rst)
			overrun <= 1'b0;
		else if (ovr_set)
			overrun <= 1'b1;
		else if (ovr_clear)
			overrun <= 1'b0;
	end

	// Receive mode in force when the overrun was taken
	always_ff @(posedge clk_i) begin
		if (port_rst)
			ovr_single <= 1'b0;
		else if (ovr_set)
			ovr_single <= ctrl.single_receive_enable && !ctrl.continuous_receive_enable;
		else if (ovr_clear)
			ovr_single <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Status and interrupt

	// R13 ninth bit of oldest
	// R17 flag on finished char
	always_comb begin
		status.fifo_count             = count;
		status.receive_interrupt_flag = count != '0;
		status.overrun_flag           = overrun;
		status.ninth_received_bit     = (count != '0) ? fifo_mem[head][8] : 1'b0;
	end

	// Port disable drops the request together with the FIFO
	// R17 gated interrupt out
	always_ff @(posedge clk_i) begin
		if (port_rst)
			rx_irq_o <= 1'b0;
		else
			rx_irq_o <= status.receive_interrupt_flag && ctrl.receive_interrupt_enable;
	end

endmodule
`default_nettype wire

// >>> design/ssr_params.svh
// Constants of the synchronous serial receive path
//
// Contract
// R1 - As slave, the bit clock comes in on the shared clock/transmit pin.
// R2 - As slave, the driver of the shared clock/transmit pin is switched off.
// R3 - Data changes on the leading clock edge and is sampled at the trailing edge.
// R4 - One data bit moves across the link per clock cycle.
// R5 - An external master gives a slave only as many clocks as data bits.
// R6 - Up to two finished characters wait in a FIFO before the data port.
// R7 - A third whole character arriving while the FIFO is full sets overrun.
// R8 - On overrun, stored characters stay readable; nothing more is received until cleared.
// R9 - Overrun cannot be written; it clears only when its condition is removed.
// R10 - Overrun taken in single receive without continuous clears on a data read.
// R11 - Overrun under continuous receive clears when continuous or port enable is cleared.
// R12 - With nine-bit receive, nine bits are shifted per character instead of eight.
// R13 - The ninth-bit field shows the top bit of the oldest unread character.
// R14 - Software reads the ninth bit before the low eight data bits.
// R15 - Software sets divisor, speed selects, then port enable and master clock, receive off.
// R16 - Reception starts on single or continuous receive enable; then data is clocked in.
// R17 - A finished character sets the receive flag; interrupt raised when enabled.
// R18 - Software sets receive, global and peripheral interrupt enables for interrupts.
// R19 - Software reads status for ninth bit and errors before the data.
// R20 - As master, the block drives the clock from its baud generator while receiving.
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

`define SSR_OFS_CTRL     4'h0
`define SSR_OFS_STATUS   4'h4
`define SSR_OFS_DATA     4'h8
`define SSR_OFS_BAUD     4'hc

`define SSR_CTRL_RESET   8'h00
`define SSR_BAUD_RESET   16'h0000

`define SSR_ST_NINTH     0
`define SSR_ST_OVERRUN   1
`define SSR_ST_RXFLAG    2
`define SSR_ST_COUNT     3

`define SSR_FIFO_DEPTH   2
`define SSR_BITS_SHORT   4'h8
`define SSR_BITS_LONG    4'h9

`endif

// >>> design/ssr_pkg.sv
// Types of the synchronous serial receive path
`default_nettype none
package ssr_pkg;

	// Control register, bit 0 first from the bottom
	typedef struct packed {
		logic wide_baud_generator_select;
		logic high_speed_baud_select;
		logic receive_interrupt_enable;
		logic nine_bit_receive_enable;
		logic continuous_receive_enable;
		logic single_receive_enable;
		logic master_clock_source_select;
		logic serial_port_enable;
	} ssr_ctrl_t;

	typedef struct packed {
		logic [1:0] fifo_count;
		logic       receive_interrupt_flag;
		logic       overrun_flag;
		logic       ninth_received_bit;
	} ssr_status_t;

	typedef enum logic [1:0] {
		SSR_RX_IDLE  = 2'b00,
		SSR_RX_SHIFT = 2'b01,
		SSR_RX_STALL = 2'b11
	} ssr_rx_state_t;

endpackage
`default_nettype wire

// >>> design/ssr_baud_gen.sv
// Baud rate tick divider for the master bit clock
`default_nettype none
module ssr_baud_gen #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Control
	input  wire logic         en_i,
	input  wire logic [W-1:0] div_i,
	// Tick out
	output logic              tick_o
);

	logic [W-1:0] cnt;

	// One tick every div_i + 1 cycles
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end else if (cnt == '0) begin
			cnt    <= div_i;
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt - 1'b1;
			tick_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> dv/ssr_chk_assertions.sv
// Port assertions of the synchronous serial receive path
`default_nettype none
module ssr_chk #(
	parameter int DEPTH  = 2,
	parameter int BAUD_W = 16
) (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Link and interrupt
	input wire logic        shared_clock_transmit_pin_i,
	input wire logic        shared_clock_transmit_pin_o,
	input wire logic        shared_clock_transmit_pin_oe_n_o,
	input wire logic        rx_data_pin_i,
	input wire logic        rx_irq_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic       rd_q;
	logic [1:0] adr_q;
	always_ff @(posedge clk_i) begin
		rd_q  <= wb_cyc_i && wb_stb_i && !wb_we_i;
		adr_q <= wb_adr_i[3:2];
	end
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !rx_irq_o &&
		shared_clock_transmit_pin_oe_n_o) else $error("not quiet after reset");
	a_read_data_holds: assert property (!wb_ack_o && !$past(rst_i) |-> $stable(wb_dat_o))
		else $error("read data moved");
	a_slave_clock_quiet: assert property (
		shared_clock_transmit_pin_oe_n_o |-> !shared_clock_transmit_pin_o)
		else $error("clock driven while released");
	a_master_clock_driven: assert property ($rose(shared_clock_transmit_pin_o) |->
		!shared_clock_transmit_pin_oe_n_o && !$past(shared_clock_transmit_pin_oe_n_o))
		else $error("clock edge without driver");
	a_data_low_eight: assert property (
		wb_ack_o && rd_q && adr_q == 2'h2 |-> wb_dat_o[31:8] == 24'h0)
		else $error("data port too wide");
	a_irq_fall_cause: assert property (
		$fell(rx_irq_o) && !$past(rst_i) |-> wb_ack_o || $past(wb_ack_o))
		else $error("irq dropped without access");
	c_irq_rise: cover property ($rose(rx_irq_o));
	c_master_clock: cover property ($rose(shared_clock_transmit_pin_o));
	c_data_read: cover property (wb_ack_o && rd_q && adr_q == 2'h2);
endmodule
bind ssr_top ssr_chk #(.DEPTH(DEPTH), .BAUD_W(BAUD_W)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.shared_clock_transmit_pin_i(shared_clock_transmit_pin_i),
	.shared_clock_transmit_pin_o(shared_clock_transmit_pin_o),
	.shared_clock_transmit_pin_oe_n_o(shared_clock_transmit_pin_oe_n_o),
	.rx_data_pin_i(rx_data_pin_i), .rx_irq_o(rx_irq_o)
);
`default_nettype wire

// >>> dv/ssr_far_end.sv
// Behavioural far end of the synchronous serial link
`default_nettype none
module ssr_far_end (
	// Clock from the block as master
	input  wire logic       mclk_i,
	input  wire logic       oe_n_i,
	// Frame request and content
	input  wire logic       go_i,
	input  wire logic [8:0] word_i,
	input  wire logic [3:0] nbits_i,
	// Lines towards the block
	output logic            sclk_o,
	output logic            dat_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] idx   = 4'h0;
	logic       m_dat = 1'b1;
	logic       s_dat = 1'b1;
	logic       s_clk = 1'b0;
	assign sclk_o = s_clk;
	assign dat_o  = oe_n_i ? s_dat : m_dat;
	// bit changes on rising clock; line flips after the last fall
	always @(mclk_i) begin
		if (oe_n_i === 1'b0) begin
			if (mclk_i === 1'b1) begin
				m_dat = word_i[idx];
				idx   = idx + 4'h1;
			end else if (idx == nbits_i) begin
				m_dat = ~m_dat;
				idx   = 4'h0;
			end
		end
	end
	always @(posedge go_i) begin
		#3.3;
		for (int i = 0; i < nbits_i; i++) begin
			s_clk = 1'b1;
			s_dat = word_i[i];
			#40;
			s_clk = 1'b0;
			#40;
		end
		s_dat = ~s_dat;
	end
endmodule
`default_nettype wire

// >>> dv/ssr_top_test.sv
// Self-checking bench of the synchronous serial receive path
`include "ssr_params.svh"
`default_nettype none
module ssr_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i, rst_i, cyc, stb, we, go, sclk, pdat, ack, pin_o, oe_n, irq;
	logic [3:0]  adr, nb;
	logic [31:0] wdat, rdat;
	logic [8:0]  word;
	int          error_cnt = 0, n_tests = 0, cycles = 0;
	ssr_top dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.shared_clock_transmit_pin_i(oe_n ? sclk : pin_o), .shared_clock_transmit_pin_o(pin_o),
		.shared_clock_transmit_pin_oe_n_o(oe_n), .rx_data_pin_i(pdat), .rx_irq_o(irq)
	);
	ssr_far_end far (
		.mclk_i(pin_o), .oe_n_i(oe_n), .go_i(go), .word_i(word), .nbits_i(nb),
		.sclk_o(sclk), .dat_o(pdat)
	);
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	task automatic poll(input logic [31:0] e);
		logic [31:0] r;
		int n = 0;
		do begin
			xfer(1'b0, `SSR_OFS_STATUS, 32'h0, r);
			n++;
		end while (r !== e && n < 200);
		chk(r, e);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, go, adr, wdat} = '0;
		word = 9'h0a5;
		nb = 4'h8;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`SSR_OFS_CTRL, 32'h0);
		rd(`SSR_OFS_BAUD, 32'h0);
		rd(`SSR_OFS_STATUS, 32'h0);
		$display("reset test done");
		wr(`SSR_OFS_BAUD, 32'h3);
		wr(`SSR_OFS_CTRL, 32'h03);
		for (int k = 0; k < 3; k++) begin
			wr(`SSR_OFS_CTRL, 32'h27);
			poll(k == 0 ? 32'h0c : k == 1 ? 32'h14 : 32'h16);
		end
		chk({31'h0, irq}, 32'h1);
		rd(`SSR_OFS_DATA, 32'ha5);
		rd(`SSR_OFS_STATUS, 32'h0c);
		rd(`SSR_OFS_DATA, 32'ha5);
		rd(`SSR_OFS_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("single receive test done");
		word = 9'h1c3;
		nb = 4'h9;
		wr(`SSR_OFS_CTRL, 32'h1b);
		poll(32'h17);
		chk({31'h0, oe_n}, 32'h0);
		wr(`SSR_OFS_STATUS, 32'h0);
		rd(`SSR_OFS_STATUS, 32'h17);
		rd(`SSR_OFS_DATA, 32'hc3);
		rd(`SSR_OFS_STATUS, 32'h0f);
		wr(`SSR_OFS_CTRL, 32'h13);
		rd(`SSR_OFS_STATUS, 32'h0d);
		rd(`SSR_OFS_DATA, 32'hc3);
		wr(`SSR_OFS_CTRL, 32'h0);
		$display("continuous receive test done");
		for (int i = 0; i < 2; i++) begin
			word = i ? 9'h15a : 9'h05a;
			nb = i ? 4'h9 : 4'h8;
			wr(`SSR_OFS_CTRL, 32'h03);
			wr(`SSR_OFS_CTRL, i ? 32'h15 : 32'h05);
			@(posedge clk_i);
			chk({31'h0, oe_n}, 32'h1);
			go <= 1'b1;
			@(posedge clk_i);
			go <= 1'b0;
			poll(i ? 32'h0d : 32'h0c);
			rd(`SSR_OFS_DATA, 32'h5a);
		end
		$display("slave receive test done");
		test_done();
	end
endmodule
`default_nettype wire
